// ==== pkg/dof_pkg.sv ====
`default_nettype none

package dof_pkg;

  // Register byte offsets on the APB
  localparam logic [11:0] ADDR_CLOCK_MODE  = 12'h000;
  localparam logic [11:0] ADDR_OUTPUT_MODE = 12'h004;
  localparam logic [11:0] ADDR_DATA_FORMAT = 12'h008;
  localparam logic [11:0] ADDR_STATUS      = 12'h00C;

  // Clock mode register fields
  localparam int CLK_DCS_BIT    = 0;
  localparam int CLK_PHASE_LSB  = 1;
  localparam int CLK_INVERT_BIT = 3;

  // Output mode register fields
  localparam int OUT_MODE_LSB    = 0;
  localparam int OUT_CURRENT_LSB = 2;
  localparam int OUT_TERM_BIT    = 5;

  // Data format register fields
  localparam int FMT_TWOS_BIT = 0;
  localparam int FMT_RAND_BIT = 1;

  // Status register fields
  localparam int STAT_LOCK_BIT   = 0;
  localparam int STAT_DCS_BIT    = 1;
  localparam int STAT_PERIOD_LSB = 8;

  // Reset values: every mode bit clears to zero
  localparam logic [7:0] CLOCK_MODE_RST  = 8'h00;
  localparam logic [7:0] OUTPUT_MODE_RST = 8'h00;
  localparam logic [7:0] DATA_FORMAT_RST = 8'h00;

  // Sample word and lane geometry
  localparam int          CODE_WIDTH = 16;
  localparam int          LANES      = 8;
  localparam logic [15:0] CODE_MAX   = 16'hFFFF;
  localparam logic [15:0] CODE_MIN   = 16'h0000;

  // Encode cycles of steady period before the stabilizer counts as locked
  localparam int LOCK_CYCLES = 100;

  // Output modes
  typedef enum logic [1:0] {
    OUT_FULL_CMOS = 2'b00,
    OUT_DDR_CMOS  = 2'b01,
    OUT_DDR_LVDS  = 2'b10
  } dof_mode_t;

  // LVDS driver current selections; zero is the 3.5 mA default
  localparam logic [2:0] CUR_3P5MA  = 3'h0;
  localparam logic [2:0] CUR_4P0MA  = 3'h1;
  localparam logic [2:0] CUR_4P5MA  = 3'h2;
  localparam logic [2:0] CUR_3P0MA  = 3'h3;
  localparam logic [2:0] CUR_2P5MA  = 3'h4;
  localparam logic [2:0] CUR_2P1MA  = 3'h5;
  localparam logic [2:0] CUR_1P75MA = 3'h6;

  // Stabilizer lock states
  typedef enum logic [1:0] {
    LK_IDLE    = 2'b00,
    LK_ACQUIRE = 2'b01,
    LK_LOCKED  = 2'b10
  } dof_lock_t;

  // Raw result from the converter core
  typedef struct packed {
    logic        over;
    logic        under;
    logic [15:0] code;
  } dof_core_t;

  // Formatted sample with its range flag
  typedef struct packed {
    logic        flag;
    logic [15:0] code;
  } dof_sample_t;

endpackage

`default_nettype wire

// ==== rtl/dof_output_formatter.sv ====
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dof_output_formatter
  import dof_pkg::*;
#(
  parameter int PERW = 8   // Width of the encode period counter
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device pins
  input  wire logic        encode_clock_input,
  input  wire logic        programming_style_select,
  input  wire logic        par_dcs_select,
  input  wire logic        par_output_select,
  // Converter core results
  input  wire logic [15:0] ch1_core_code,
  input  wire logic        ch1_core_over,
  input  wire logic        ch1_core_under,
  input  wire logic [15:0] ch2_core_code,
  input  wire logic        ch2_core_over,
  input  wire logic        ch2_core_under,
  // Sample outputs
  output logic             forwarded_sample_clock,
  output logic      [15:0] data_ch1,
  output logic      [15:0] data_ch2,
  output logic             range_flag_ch1,
  output logic             range_flag_ch2,
  output logic       [7:0] ch1_lane_bits,
  output logic       [7:0] ch2_lane_bits,
  output logic             shared_range_flag,
  // Output driver controls and status
  output dof_mode_t        output_mode,
  output logic       [2:0] lvds_current_sel,
  output logic             lvds_termination,
  output logic             lvds_current_double,
  output logic             sample_clock_locked
);

  // Period counter must hold a few cycles and fit the status field
  if (PERW < 4 || PERW > 16) begin : g_bad_perw
    $error("PERW must lie between 4 and 16");
  end

  localparam logic [PERW-1:0] PER_MAX = {PERW{1'b1}};

  // Software registers
  logic [7:0] clock_mode_register;    // Stabilizer, phase, invert
  logic [7:0] output_mode_register;   // Mode, current, termination
  logic [7:0] data_format_register;   // Twos complement, randomizer

  // Pin synchronisers; stage one is read only by stage two
  logic      enc_s1, enc_s2, enc_s3;
  logic      style_s1, style_s2;
  logic      pdcs_s1, pdcs_s2;
  logic      pout_s1, pout_s2;
  dof_core_t core1_s1, core1_s2, core2_s1, core2_s2;

  // Timing state
  logic [PERW-1:0] ph_cnt;            // Cycles since last encode rise
  logic [PERW-1:0] period;            // Last measured encode period
  logic [7:0]      lock_cnt;          // Steady periods seen
  dof_lock_t       lock_state;
  logic            int_hi_q;          // Internal sample clock, delayed

  // Sample pipeline
  dof_sample_t cap1, cap2;            // Taken at encode rise
  dof_sample_t word1, word2;          // Word being presented

  // APB decode
  wire       apb_setup  = psel & ~penable;
  wire       apb_access = psel & penable & ~pready;
  wire       hit_clk    = (paddr == ADDR_CLOCK_MODE);
  wire       hit_out    = (paddr == ADDR_OUTPUT_MODE);
  wire       hit_fmt    = (paddr == ADDR_DATA_FORMAT);
  wire       hit_stat   = (paddr == ADDR_STATUS);
  wire       addr_ok    = hit_clk | hit_out | hit_fmt | hit_stat;
  // Write lands only at the edge that completes the transfer
  wire       wr_en      = psel & penable & pready & pwrite & clk_en;

  // Effective configuration: parallel style overrides from pins
  wire       parallel   = style_s2;
  wire       dcs_en     = parallel ? pdcs_s2 : clock_mode_register[CLK_DCS_BIT];
  wire [1:0] phase_sel  = clock_mode_register[CLK_PHASE_LSB +: 2];
  wire       clk_invert = clock_mode_register[CLK_INVERT_BIT];
  // Formatting bits are serial-only, so parallel style sees defaults
  wire       twos_en    = ~parallel & data_format_register[FMT_TWOS_BIT];
  wire       rand_en    = ~parallel & data_format_register[FMT_RAND_BIT];
  wire [1:0] reg_mode   = output_mode_register[OUT_MODE_LSB +: 2];
  wire [2:0] cur_sel    = parallel ? CUR_3P5MA : output_mode_register[OUT_CURRENT_LSB +: 3];
  wire       term_en    = ~parallel & output_mode_register[OUT_TERM_BIT];

  // Mode select; the pin can only pick full CMOS or DDR LVDS
  dof_mode_t next_mode;
  always_comb begin
    if (parallel) begin
      next_mode = pout_s2 ? OUT_DDR_LVDS : OUT_FULL_CMOS;
    end else begin
      case (reg_mode)
        2'b01:   next_mode = OUT_DDR_CMOS;
        2'b10:   next_mode = OUT_DDR_LVDS;
        default: next_mode = OUT_FULL_CMOS;
      endcase
    end
  end
  wire ddr = (next_mode != OUT_FULL_CMOS);

  // Encode edge and period measurement
  wire            enc_rise   = enc_s2 & ~enc_s3;
  wire [PERW-1:0] next_period = (ph_cnt == PER_MAX) ? PER_MAX : ph_cnt + 1'b1;
  wire [PERW-1:0] per_diff   = (next_period > period) ? next_period - period
                                                      : period - next_period;
  // One cycle of slack absorbs the sampling jitter of the edge detector
  wire            period_match = (per_diff <= {{(PERW-1){1'b0}}, 1'b1});
  wire [PERW-1:0] half       = period >> 1;

  // Stabilized clock is high for the first half period regardless of input duty
  wire int_hi = dcs_en ? (ph_cnt < half) : enc_s2;
  wire fall_evt = int_hi_q & ~int_hi;
  wire rise_evt = ~int_hi_q & int_hi;

  // Phase delay in eighths of a period; forced to zero without stabilizer
  wire [PERW+1:0] shift_prod = {2'b00, period} * {{PERW{1'b0}}, phase_sel};
  wire [PERW-1:0] shift      = dcs_en ? {1'b0, shift_prod[PERW+1:3]} : '0;
  wire [PERW-1:0] ph_shift   = ph_cnt - shift + ((ph_cnt < shift) ? period : '0);
  wire            fwd_hi     = dcs_en ? (ph_shift < half) : enc_s2;

  // Clamp, then format, then randomize
  function automatic dof_sample_t fmt_sample(dof_core_t raw, logic twos, logic rnd);
    dof_sample_t s;
    s.flag = raw.over | raw.under;
    s.code = raw.over ? CODE_MAX : (raw.under ? CODE_MIN : raw.code);
    if (twos) begin
      s.code[15] = ~s.code[15];
    end
    if (rnd) begin
      s.code[15:1] = s.code[15:1] ^ {15{s.code[0]}};
    end
    return s;
  endfunction

  // Source words for the lanes: a falling event starts the new sample
  wire [15:0] src1 = fall_evt ? cap1.code : word1.code;
  wire [15:0] src2 = fall_evt ? cap2.code : word2.code;
  wire  [7:0] next_lane1, next_lane2;

  // Each lane shows the even bit while low and the odd bit while high
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign next_lane1[i] = rise_evt ? src1[2*i+1] : src1[2*i];
    assign next_lane2[i] = rise_evt ? src2[2*i+1] : src2[2*i];
  end

  // Shared flag: channel 2 while low, channel 1 while high
  wire next_shared = rise_evt ? word1.flag : cap2.flag;

  // Synchronisers for pins and core results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {enc_s1, enc_s2, enc_s3}  <= 3'h0;
      {style_s1, style_s2}      <= 2'h0;
      {pdcs_s1, pdcs_s2}        <= 2'h0;
      {pout_s1, pout_s2}        <= 2'h0;
      {core1_s1, core1_s2}      <= '0;
      {core2_s1, core2_s2}      <= '0;
    end else if (clk_en) begin
      {enc_s3, enc_s2, enc_s1}  <= {enc_s2, enc_s1, encode_clock_input};
      {style_s2, style_s1}      <= {style_s1, programming_style_select};
      {pdcs_s2, pdcs_s1}        <= {pdcs_s1, par_dcs_select};
      {pout_s2, pout_s1}        <= {pout_s1, par_output_select};
      core1_s1 <= {ch1_core_over, ch1_core_under, ch1_core_code};
      core1_s2 <= core1_s1;
      core2_s1 <= {ch2_core_over, ch2_core_under, ch2_core_code};
      core2_s2 <= core2_s1;
    end
  end

  // Phase counter restarts on every encode rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_cnt <= '0;
      period <= '0;
    end else if (clk_en) begin
      ph_cnt <= enc_rise ? '0 : (ph_cnt == PER_MAX ? PER_MAX : ph_cnt + 1'b1);
      if (enc_rise) begin
        period <= next_period;
      end
    end
  end

  // Lock tracker: a period change restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_state <= LK_IDLE;
      lock_cnt   <= 8'h00;
    end else if (clk_en) begin
      if (!dcs_en) begin
        lock_state <= LK_IDLE;
        lock_cnt   <= 8'h00;
      end else if (enc_rise) begin
        case (lock_state)
          LK_IDLE: begin
            lock_state <= LK_ACQUIRE;
            lock_cnt   <= 8'h00;
          end
          LK_ACQUIRE: begin
            if (!period_match) begin
              lock_cnt <= 8'h00;
            end else if (lock_cnt == 8'(LOCK_CYCLES - 1)) begin
              lock_state <= LK_LOCKED;
              lock_cnt   <= 8'(LOCK_CYCLES);
            end else begin
              lock_cnt <= lock_cnt + 8'h01;
            end
          end
          LK_LOCKED: begin
            // Frequency moved: start the hundred-cycle wait again
            if (!period_match) begin
              lock_state <= LK_ACQUIRE;
              lock_cnt   <= 8'h00;
            end
          end
          default: begin
            lock_state <= LK_IDLE;
            lock_cnt   <= 8'h00;
          end
        endcase
      end
    end
  end

  // Sample capture and presentation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap1  <= '0;
      cap2  <= '0;
      word1 <= '0;
      word2 <= '0;
    end else if (clk_en) begin
      if (enc_rise) begin
        cap1 <= fmt_sample(core1_s2, twos_en, rand_en);
        cap2 <= fmt_sample(core2_s2, twos_en, rand_en);
      end
      if (fall_evt) begin
        word1 <= cap1;
        word2 <= cap2;
      end
    end
  end

  // Output pins; data and forwarded clock leave the same flop stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_hi_q               <= 1'b0;
      forwarded_sample_clock <= 1'b0;
      {data_ch1, data_ch2}   <= 32'h0000_0000;
      {range_flag_ch1, range_flag_ch2} <= 2'h0;
      {ch1_lane_bits, ch2_lane_bits}   <= 16'h0000;
      shared_range_flag      <= 1'b0;
      output_mode            <= OUT_FULL_CMOS;
      lvds_current_sel       <= CUR_3P5MA;
      lvds_termination       <= 1'b0;
      lvds_current_double    <= 1'b0;
      sample_clock_locked    <= 1'b0;
    end else if (clk_en) begin
      int_hi_q               <= int_hi;
      forwarded_sample_clock <= fwd_hi ^ clk_invert;
      output_mode            <= next_mode;
      lvds_current_sel       <= cur_sel;
      lvds_termination       <= term_en;
      lvds_current_double    <= term_en;
      sample_clock_locked    <= (lock_state == LK_LOCKED);
      if (ddr) begin
        // Unused full-rate pins rest low in DDR modes
        {data_ch1, data_ch2}             <= 32'h0000_0000;
        {range_flag_ch1, range_flag_ch2} <= 2'h0;
        if (fall_evt || rise_evt) begin
          ch1_lane_bits     <= next_lane1;
          ch2_lane_bits     <= next_lane2;
          shared_range_flag <= next_shared;
        end
      end else begin
        {ch1_lane_bits, ch2_lane_bits} <= 16'h0000;
        shared_range_flag              <= 1'b0;
        if (fall_evt) begin
          data_ch1       <= cap1.code;
          data_ch2       <= cap2.code;
          range_flag_ch1 <= cap1.flag;
          range_flag_ch2 <= cap2.flag;
        end
      end
    end
  end

  // APB register writes; reserved bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_mode_register  <= CLOCK_MODE_RST;
      output_mode_register <= OUTPUT_MODE_RST;
      data_format_register <= DATA_FORMAT_RST;
    end else if (wr_en) begin
      if (hit_clk) begin
        clock_mode_register <= {4'h0, pwdata[3:0]};
      end
      if (hit_out) begin
        output_mode_register <= {2'h0, pwdata[5:0]};
      end
      if (hit_fmt) begin
        data_format_register <= {6'h0, pwdata[1:0]};
      end
    end
  end

  // Read mux; status shows lock state and measured period
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_clk) begin
      next_prdata[7:0] = clock_mode_register;
    end else if (hit_out) begin
      next_prdata[7:0] = output_mode_register;
    end else if (hit_fmt) begin
      next_prdata[7:0] = data_format_register;
    end else if (hit_stat) begin
      next_prdata[STAT_LOCK_BIT] = (lock_state == LK_LOCKED);
      next_prdata[STAT_DCS_BIT]  = dcs_en;
      next_prdata[STAT_PERIOD_LSB +: PERW] = period;
    end
  end

  // APB answer: pready in the second access cycle, error on unmapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= apb_access;
      pslverr <= apb_access & ~addr_ok;
      if (apb_access && !pwrite) begin
        prdata <= next_prdata;
      end else if (apb_setup) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Over-range input clamps to full code with the flag raised
  AST_CLAMP_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && enc_rise && core1_s2.over && !twos_en && !rand_en
      |=> cap1.code == CODE_MAX && cap1.flag)
    else $error("over-range sample not clamped");

  // Twos complement differs from offset binary only in the MSB
  AST_TWOS_MSB: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && enc_rise && twos_en && !rand_en && !core1_s2.over && !core1_s2.under
      |=> cap1.code == {~$past(core1_s2.code[15]), $past(core1_s2.code[14:0])})
    else $error("twos complement code wrong");

  // Undoing the randomizer with the LSB restores the sample
  AST_RANDOMIZE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && enc_rise && rand_en && !twos_en && !core1_s2.over && !core1_s2.under
      |=> (cap1.code ^ {{15{cap1.code[0]}}, 1'b0}) == $past(core1_s2.code))
    else $error("randomized word does not decode");

  // Full-rate data only moves as the unshifted forwarded clock falls
  AST_FULL_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && output_mode == OUT_FULL_CMOS && $past(output_mode) == OUT_FULL_CMOS
      && phase_sel == 2'b00 && !clk_invert && data_ch1 != $past(data_ch1)
      |-> !forwarded_sample_clock && $past(forwarded_sample_clock))
    else $error("full-rate data changed off the falling edge");

  // Even bit shows after the falling event
  AST_LANE_EVEN: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ddr && fall_evt |=> ch1_lane_bits[0] == $past(cap1.code[0])
      && ch1_lane_bits[7] == $past(cap1.code[14]))
    else $error("lane did not show even bits");

  // Channel 1 flag follows the rising event
  AST_SHARED_CH1: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ddr && rise_evt |=> shared_range_flag == $past(word1.flag))
    else $error("shared flag not channel 1 while high");

  // Lock arrives on the hundredth steady period
  AST_LOCK_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && dcs_en && enc_rise && lock_state == LK_ACQUIRE && period_match
      && lock_cnt == 8'(LOCK_CYCLES - 1) |=> clk_en |-> ##1 sample_clock_locked)
    else $error("stabilizer lock timing wrong");

  // Parallel style never produces DDR CMOS
  AST_PAR_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && parallel |=> output_mode != OUT_DDR_CMOS)
    else $error("DDR CMOS reached from parallel style");

  // No phase delay without the stabilizer: forwarded clock follows the encode level
  AST_SHIFT_DCS: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !dcs_en |=> forwarded_sample_clock == ($past(enc_s2) ^ $past(clk_invert)))
    else $error("phase shift active with stabilizer off");

endmodule

`default_nettype wire

// ==== verification/dof_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
// Receiving capture logic; it latches samples when the forwarded clock rises
module dof_capture
  import dof_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Stream from the formatter
  input  wire logic        fclk,
  input  wire logic        ddr,
  input  wire logic        derand,
  input  wire logic [15:0] data,
  input  wire logic [7:0]  lanes,
  input  wire logic        flag,
  input  wire logic        sflag,
  // Recovered sample
  output logic      [15:0] word,
  output logic             wflag,
  output logic             f2,
  output int               cnt
);
  logic        prev; // Clock level one pclk ago
  logic [7:0]  even; // Even bits held from the low phase
  logic        lowf; // Flag held from the low phase
  logic [15:0] w;    // Word as it will be latched
  initial cnt = 0;
  // Rebuild the word; randomizing is undone with the received low bit
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      w[2*i] = even[i];
      w[2*i+1] = lanes[i];
    end
    if (!ddr) w = data;
    if (derand) w[15:1] = w[15:1] ^ {15{w[0]}};
  end
  // Low phase fills the holding bits; the rise latches
  always @(posedge pclk) begin
    prev <= fclk;
    if (!fclk) begin
      even <= lanes;
      lowf <= sflag;
    end
    if (fclk && !prev) begin
      word <= w;
      wflag <= ddr ? sflag : flag;
      f2 <= lowf;
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dof_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, der, wflag, f2;
  logic        encode_clock_input, programming_style_select, par_dcs_select;
  logic        par_output_select, ch1_core_over, ch1_core_under, ch2_core_over;
  logic        forwarded_sample_clock, range_flag_ch1, range_flag_ch2, shared_range_flag;
  logic        lvds_termination, lvds_current_double, sample_clock_locked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] ch1_core_code, data_ch1, data_ch2, word, ex, word2, ex2;
  logic [7:0]  ch1_lane_bits, ch2_lane_bits;
  logic [2:0]  lvds_current_sel;
  dof_mode_t   output_mode;
  int          n_mismatch, checked, cnt, n0, n1;
  // Case table: core code, format register, range (over, under)
  logic [15:0] tc [9] = '{16'h8000, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h1234, 16'h1234,
                          16'h1234, 16'h0003, 16'h8001};
  logic [1:0]  tf [9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
  logic [1:0]  tr [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0};

  dof_output_formatter dof_output_formatter_i (
    .pclk, .presetn, .clk_en(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .encode_clock_input, .programming_style_select, .par_dcs_select,
    .par_output_select, .ch1_core_code, .ch1_core_over, .ch1_core_under,
    .ch2_core_code(ch1_core_code), .ch2_core_over, .ch2_core_under(ch1_core_under),
    .forwarded_sample_clock, .data_ch1, .data_ch2, .range_flag_ch1, .range_flag_ch2,
    .ch1_lane_bits, .ch2_lane_bits, .shared_range_flag, .output_mode, .lvds_current_sel,
    .lvds_termination, .lvds_current_double, .sample_clock_locked);
  dof_capture dof_capture_i (
    .pclk, .fclk(forwarded_sample_clock), .ddr(output_mode != OUT_FULL_CMOS), .derand(der),
    .data(data_ch1), .lanes(ch1_lane_bits), .flag(range_flag_ch1),
    .sflag(shared_range_flag), .word, .wflag, .f2, .cnt);
  // Second receiver rebuilds channel 2 from its own pins
  dof_capture dof_capture_ch2 (
    .pclk, .fclk(forwarded_sample_clock), .ddr(output_mode != OUT_FULL_CMOS), .derand(der),
    .data(data_ch2), .lanes(ch2_lane_bits), .flag(range_flag_ch2),
    .sflag(shared_range_flag), .word(word2), .wflag(), .f2(), .cnt());

  // Bus clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Encode clock, off phase; 12.5 Msps keeps the stabilizer in range
  initial begin
    encode_clock_input = 1'b0;
    #3;
    forever #40 encode_clock_input = ~encode_clock_input;
  end

  // Compare and count
  task chk(input string nm, input logic [31:0] exv, input logic [31:0] got);
    checked++;
    if (got !== exv) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exv, got);
    end
  endtask
  // Verdict and end of run
  task close_out;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer; read data and error land in r and e
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
    if (i >= 20) begin
      n_mismatch++;
      close_out;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Let n samples reach the receiver; a stalled stream ends the run
  task samples(input int n);
    int s;
    s = cnt;
    for (int i = 0; i < 40 * n && cnt < s + n; i++) @(posedge pclk);
    if (cnt < s + n) begin
      n_mismatch++;
      close_out;
    end
  endtask
  // Pclk edges from an encode rise to the rise of the true forwarded clock
  task fwd_rise(input logic inv, output int n);
    logic p;
    n = 0;
    p = 1'b1;
    repeat (2) @(posedge encode_clock_input);
    while (n < 40 && !(p === 1'b0 && (forwarded_sample_clock ^ inv) === 1'b1)) begin
      p = forwarded_sample_clock ^ inv;
      @(posedge pclk);
      n++;
    end
  endtask
  // Expected code after clamping and format choice
  function automatic logic [15:0] fmt(input logic o, u, tw, input logic [15:0] c);
    logic [15:0] v;
    v = o ? CODE_MAX : (u ? CODE_MIN : c);
    v[15] = v[15] ^ tw;
    return v;
  endfunction

  initial begin
    {presetn, psel, penable, pwrite, der, ch1_core_over, ch1_core_under} = '0;
    {programming_style_select, par_dcs_select, par_output_select, ch2_core_over} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ch1_core_code = 16'h8000;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped word
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      chk("reset reg", 32'h0, r);
    end
    chk("default current", CUR_3P5MA, lvds_current_sel);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 1'b1, e);
    $display("test registers done");
    // Stabilizer needs a hundred steady periods
    apb(1'b1, ADDR_CLOCK_MODE, 32'h1);
    repeat (500) @(posedge pclk);
    chk("early lock", 1'b0, sample_clock_locked);
    for (int i = 0; i < 1000 && sample_clock_locked !== 1'b1; i++) @(posedge pclk);
    chk("lock", 1'b1, sample_clock_locked);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0A03, r & 32'hFF03);
    $display("test stabilizer done");
    // Delay steps by an eighth of the 10-cycle period; inversion keeps the delay
    fwd_rise(1'b0, n0);
    for (int p = 1; p < 8; p++) begin
      apb(1'b1, ADDR_CLOCK_MODE, 32'(2 * p + 1));
      fwd_rise(p[2], n1);
      chk("clock delay", (10 * (p % 4)) / 8, n1 - n0);
    end
    apb(1'b1, ADDR_CLOCK_MODE, 32'h1);
    $display("test clock phase done");
    // Every case in each of the three output modes
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, ADDR_OUTPUT_MODE, 32'(m));
      for (int k = 0; k < 9; k++) begin
        apb(1'b1, ADDR_DATA_FORMAT, 32'(tf[k]));
        der <= tf[k][1];
        ch1_core_code <= tc[k];
        {ch1_core_over, ch1_core_under} <= tr[k];
        ch2_core_over <= k[0];
        samples(4);
        ex = fmt(tr[k][1], tr[k][0], tf[k][0], tc[k]);
        chk("recovered", ex, word);
        chk("flag ch1", |tr[k], wflag);
        ex2 = fmt(k[0], tr[k][0], tf[k][0], tc[k]);
        chk("recovered ch2", ex2, word2);
        if (m == 0) begin
          chk("raw ch1", ex ^ {{15{ex[0] & tf[k][1]}}, 1'b0}, data_ch1);
          chk("flag ch2", k[0] | tr[k][0], range_flag_ch2);
        end else begin
          chk("shared flag ch2", k[0] | tr[k][0], f2);
        end
      end
      $display("test mode %0d done", m);
    end
    // Driver current and termination
    apb(1'b1, ADDR_OUTPUT_MODE, 32'h3A);
    repeat (2) @(posedge pclk);
    chk("current", CUR_1P75MA, lvds_current_sel);
    chk("termination", 2'b11, {lvds_termination, lvds_current_double});
    $display("test driver done");
    // Parallel style pins
    programming_style_select <= 1'b1;
    par_output_select <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("par mode", OUT_DDR_LVDS, output_mode);
    chk("par termination", 1'b0, lvds_termination);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("par stabilizer", 1'b0, r[STAT_DCS_BIT]);
    par_output_select <= 1'b0;
    samples(4);
    chk("par full", OUT_FULL_CMOS, output_mode);
    chk("par format", 16'h8001, data_ch1);
    $display("test parallel done");
    close_out;
  end
endmodule
`default_nettype wire
